// >>> src/swt_pkg.sv
// Package for the self wake-up timer: register offsets, field positions,
// reset values and timing constants.
// Assumes a 125 MHz system clock and a slow oscillator near 10 kHz.
package swt_pkg;

  // ----------------------------------------
  // Register map (plain port addresses)
  // ----------------------------------------
  localparam logic [7:0] SWT_OFF_RELOAD = 8'h86;
  localparam logic [7:0] SWT_OFF_CTRL = 8'h8f;
  localparam logic [7:0] SWT_OFF_IRQ_STAT = 8'h90;
  localparam logic [7:0] SWT_OFF_IRQ_MASK = 8'h91;
  localparam logic [7:0] SWT_OFF_COUNT = 8'h92;

  // ----------------------------------------
  // Control register fields
  // ----------------------------------------
  localparam int SWT_CTRL_PS_LSB = 0;
  localparam int SWT_CTRL_RUN_BIT = 3;
  localparam int SWT_CTRL_OVF_BIT = 4;
  localparam logic [7:0] SWT_CTRL_RESET = 8'h00;
  localparam logic [7:0] SWT_RELOAD_RESET = 8'h00;
  localparam logic [7:0] SWT_COUNT_RESET = 8'h00;
  localparam logic [7:0] SWT_COUNT_MAX = 8'hff;
  localparam logic [7:0] SWT_MASK_RESET = 8'h00;

  // ----------------------------------------
  // Prescaler: tick count minus one per select code
  // ----------------------------------------
  localparam int SWT_PS_W = 11;
  localparam logic [SWT_PS_W-1:0] SWT_PS_DIV [8] = '{
    11'h000, 11'h003, 11'h00f, 11'h03f, 11'h0ff, 11'h1ff, 11'h3ff, 11'h7ff};

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int SWT_SYS_CLK_KHZ = 125000;
  localparam int SWT_SLOW_CLK_KHZ = 10;
  localparam int SWT_SYNC_STAGES = 2;

endpackage

// >>> src/swt_prescaler.sv
// Prescaler of the self wake-up timer: divides slow-clock ticks by the
// selected ratio and emits a one-cycle count enable.
// Assumes tick_in is a one-cycle pulse in the system clock domain.
`timescale 1ns/1ps
`default_nettype none
module swt_prescaler
  import swt_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic run,
  input wire logic tick_in,
  input wire logic [2:0] sel,
  output logic tick_out
);
  import swt_pkg::*;

  logic [SWT_PS_W-1:0] cnt_q;
  logic [SWT_PS_W-1:0] cnt_d;
  wire last_w = (cnt_q >= SWT_PS_DIV[sel]);

  // Halted prescaler keeps its count so a restart continues the period
  assign cnt_d = (run && tick_in) ? (last_w ? '0 : cnt_q + 1'b1) : cnt_q;
  assign tick_out = run && tick_in && last_w;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

endmodule
`default_nettype wire

// >>> src/swt_timer.sv
// Self wake-up timer: 8-bit auto-reload up-counter fed by the slow
// oscillator through a prescaler, with control and reload registers.
// Assumes a register port with one-cycle strobes and the slow clock
// arriving as a level input that runs on into low-power modes.
//
// Implementation choice: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none

// How it works
// - The counter keeps running in idle and power-down, as nothing here looks at power mode.
// - The only count source is the slow oscillator input, nominally 10 kHz.
// - Once running, the slow-clock request stays asserted through low-power modes.
// - The core is an 8-bit up-counter with automatic reload from the reload register.
// - A three-bit select divides by 1, 4, 16, 64, 256, 512, 1024 or 2048.
// - Writing one to the run bit starts the counter and zero halts it.
// - Rolling over from ff sets the overflow flag and reloads the counter at once.
// - A set overflow flag requests service when both interrupt enables are set.
// - Hardware never clears the overflow flag; software does.
module swt_timer
  import swt_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic slow_clk,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic wake_interrupt_enable,
  input wire logic global_interrupt_enable,
  output logic wake_service_req,
  output logic irq,
  output logic wake_event,
  output logic slow_osc_keep
);
  import swt_pkg::*;

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [7:0] wake_reload_value_q;
  logic wake_run_bit_q;
  logic wake_overflow_flag_q;
  logic [2:0] wake_prescale_select_q;
  logic [7:0] count_q;
  logic [7:0] count_d;
  logic [1:0] irq_stat_q;
  logic [1:0] irq_mask_q;
  logic [7:0] reg_rdata_q;
  logic [SWT_SYNC_STAGES-1:0] slow_sync_q;
  logic slow_prev_q;

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  wire wr_reload_w = reg_wr && (reg_addr == SWT_OFF_RELOAD);
  wire wr_ctrl_w = reg_wr && (reg_addr == SWT_OFF_CTRL);
  wire wr_stat_w = reg_wr && (reg_addr == SWT_OFF_IRQ_STAT);
  wire wr_mask_w = reg_wr && (reg_addr == SWT_OFF_IRQ_MASK);

  // ----------------------------------------
  // Slow clock edge detect
  // ----------------------------------------
  // The slow clock is sampled rather than used as a clock, which is why the
  // system clock must run at least twice its rate.
  wire slow_rise_w = slow_sync_q[SWT_SYNC_STAGES-1] && !slow_prev_q;
  wire ps_tick_w;

  swt_prescaler u_ps (
    .clk(clk),
    .rstn(rstn),
    .run(wake_run_bit_q),
    .tick_in(slow_rise_w),
    .sel(wake_prescale_select_q),
    .tick_out(ps_tick_w)
  );

  // ----------------------------------------
  // Counter
  // ----------------------------------------
  // No power-mode input exists: counting never stops for idle or power-down.
  wire rollover_w = ps_tick_w && (count_q == SWT_COUNT_MAX);
  assign count_d = !ps_tick_w ? count_q :
                   rollover_w ? wake_reload_value_q :
                   count_q + 8'h01;

  // Overflow flag: set wins over a software clear in the same cycle
  wire ovf_clr_w = wr_ctrl_w && !reg_wdata[SWT_CTRL_OVF_BIT];
  wire ovf_d_w = rollover_w ? 1'b1 :
                 ovf_clr_w ? 1'b0 :
                 wake_overflow_flag_q;

  wire [1:0] stat_set_w = {wake_run_bit_q && rollover_w, rollover_w};
  wire [1:0] stat_d_w = stat_set_w | (irq_stat_q & ~(wr_stat_w ? reg_wdata[1:0] : 2'b00));

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign wake_service_req = wake_overflow_flag_q && wake_interrupt_enable &&
                            global_interrupt_enable;
  assign irq = |(irq_stat_q & irq_mask_q);
  assign wake_event = rollover_w;
  assign slow_osc_keep = wake_run_bit_q;
  assign reg_rdata = reg_rdata_q;

  // ----------------------------------------
  // Read mux
  // ----------------------------------------
  logic [7:0] rd_mux;
  always_comb begin
    case (reg_addr)
      SWT_OFF_RELOAD: rd_mux = wake_reload_value_q;
      SWT_OFF_CTRL: rd_mux = {3'b000, wake_overflow_flag_q, wake_run_bit_q,
                              wake_prescale_select_q};
      SWT_OFF_IRQ_STAT: rd_mux = {6'h00, irq_stat_q};
      SWT_OFF_IRQ_MASK: rd_mux = {6'h00, irq_mask_q};
      SWT_OFF_COUNT: rd_mux = count_q;
      default: rd_mux = 8'h00;
    endcase
  end

  // ----------------------------------------
  // Sequential
  // ----------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      slow_sync_q <= '0;
      slow_prev_q <= 1'b0;
    end else begin
      slow_sync_q <= {slow_sync_q[SWT_SYNC_STAGES-2:0], slow_clk};
      slow_prev_q <= slow_sync_q[SWT_SYNC_STAGES-1];
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wake_run_bit_q <= SWT_CTRL_RESET[SWT_CTRL_RUN_BIT];
      wake_prescale_select_q <= SWT_CTRL_RESET[SWT_CTRL_PS_LSB +: 3];
      wake_overflow_flag_q <= SWT_CTRL_RESET[SWT_CTRL_OVF_BIT];
    end else begin
      if (wr_ctrl_w) begin
        wake_run_bit_q <= reg_wdata[SWT_CTRL_RUN_BIT];
        wake_prescale_select_q <= reg_wdata[SWT_CTRL_PS_LSB +: 3];
      end
      wake_overflow_flag_q <= ovf_d_w;
    end
  end

  // Reload writes while running are taken anyway; software must avoid them.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wake_reload_value_q <= SWT_RELOAD_RESET;
      count_q <= SWT_COUNT_RESET;
    end else begin
      if (wr_reload_w) begin
        wake_reload_value_q <= reg_wdata;
      end
      count_q <= count_d;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      irq_stat_q <= 2'b00;
      irq_mask_q <= SWT_MASK_RESET[1:0];
      reg_rdata_q <= 8'h00;
    end else begin
      irq_stat_q <= stat_d_w;
      if (wr_mask_w) begin
        irq_mask_q <= reg_wdata[1:0];
      end
      reg_rdata_q <= reg_rd ? rd_mux : 8'h00;
    end
  end

endmodule
`default_nettype wire

// >>> tb/swt_timer_properties.sv
// Port checker for the self wake-up timer.
// Bound to swt_timer from the bench top; sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module swt_timer_properties
  import swt_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic wake_interrupt_enable,
  input wire logic global_interrupt_enable,
  input wire logic wake_service_req,
  input wire logic irq,
  input wire logic wake_event,
  input wire logic slow_osc_keep
);
  // ----
  // Properties
  // ----
  wire ctrl_wr = reg_wr && (reg_addr == SWT_OFF_CTRL);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rstn);
  sequence en_s;
    wake_interrupt_enable && global_interrupt_enable;
  endsequence
  sequence ctrl_wr_s;
    ctrl_wr;
  endsequence
  rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside read slot");
  run_keep_a: assert property (ctrl_wr_s |=>
    slow_osc_keep == $past(reg_wdata[SWT_CTRL_RUN_BIT]))
    else $error("oscillator request not the run bit");
  keep_hold_a: assert property (!ctrl_wr |=> $stable(slow_osc_keep))
    else $error("run bit changed without a write");
  req_enables_a: assert property (wake_service_req |-> en_s)
    else $error("service request without enables");
  halt_quiet_a: assert property (!slow_osc_keep |-> !wake_event)
    else $error("rollover while halted");
  event_pulse_a: assert property (wake_event |=> !wake_event)
    else $error("rollover pulse too long");
  event_flag_a: assert property (wake_event ##0 en_s |=> wake_service_req)
    else $error("rollover did not raise request");
  flag_sticky_a: assert property (
    wake_service_req && !ctrl_wr ##1 en_s |-> wake_service_req)
    else $error("flag cleared by hardware");
  irq_cause_a: assert property ($rose(irq) |-> $past(wake_event) || $past(reg_wr))
    else $error("interrupt without a cause");
endmodule
`default_nettype wire

// >>> tb/test_swt_timer.sv
// Self-checking bench for the self wake-up timer.
// Assumes swt_pkg and swt_timer; drives the slow clock itself.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin errors++; \
  $display("Error %s exp %h got %h", n, e, s); end end
module test_swt_timer;
  import swt_pkg::*;
  logic clk, rstn, slow_clk, reg_wr, reg_rd, wake_interrupt_enable, global_interrupt_enable;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, r, m;
  logic wake_service_req, irq, wake_event, slow_osc_keep;
  logic [7:0] offs [6] = '{SWT_OFF_RELOAD, SWT_OFF_CTRL, SWT_OFF_IRQ_STAT,
    SWT_OFF_IRQ_MASK, SWT_OFF_COUNT, 8'h55};
  int errors, cmp_count, k, ev_count;
  swt_timer dut (.clk(clk), .rstn(rstn), .slow_clk(slow_clk), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .wake_interrupt_enable(wake_interrupt_enable),
    .global_interrupt_enable(global_interrupt_enable), .wake_service_req(wake_service_req),
    .irq(irq), .wake_event(wake_event), .slow_osc_keep(slow_osc_keep));
  // ----
  // Tasks
  // ----
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // Counts rollover pulses so that a missed or doubled one shows up
  always @(posedge clk) begin
    if (wake_event === 1'b1) ev_count++;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    `CHK("rdata", e, reg_rdata)
  endtask
  // Slow rises are 8 system clocks apart, well inside the 2x margin
  task automatic rise(input int n);
    repeat (n) begin
      @(posedge clk);
      slow_clk <= 1'b1;
      repeat (4) @(posedge clk);
      slow_clk <= 1'b0;
      repeat (3) @(posedge clk);
    end
    repeat (6) @(posedge clk);
  endtask
  task automatic wrap_up;
    $display("Comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Slow rises needed for one count step at each select code
  function automatic int div_of(input int p);
    case (p)
      0: div_of = 1;
      1: div_of = 4;
      2: div_of = 16;
      3: div_of = 64;
      4: div_of = 256;
      5: div_of = 512;
      6: div_of = 1024;
      default: div_of = 2048;
    endcase
  endfunction
  // ----
  // Sequence
  // ----
  // About 4200 slow rises of 8 clocks each are needed; 60000 leaves margin
  initial begin
    repeat (60000) @(posedge clk);
    errors++;
    wrap_up;
  end
  initial begin
    rstn = 1'b0;
    {slow_clk, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    {wake_interrupt_enable, global_interrupt_enable} = 2'b11;
    k = $urandom(32'h6f69f9fc);
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    foreach (offs[i]) rd(offs[i], 8'h00);
    // Reload stays at or below f9 so the later k steps from it cannot reach ff and roll over again
    r = 8'($urandom_range(249));
    wr(SWT_OFF_RELOAD, r);
    rd(SWT_OFF_RELOAD, r);
    wr(SWT_OFF_CTRL, 8'he7);
    rd(SWT_OFF_CTRL, 8'h07);
    rise(20);
    rd(SWT_OFF_COUNT, 8'h00);
    // The count register is read-only: a write must leave it alone
    wr(SWT_OFF_COUNT, 8'hff);
    rd(SWT_OFF_COUNT, 8'h00);
    m = 8'h00;
    for (int p = 0; p < 8; p++) begin
      wr(SWT_OFF_CTRL, 8'h08 | 8'(p));
      rise(div_of(p));
      m++;
      rd(SWT_OFF_COUNT, m);
    end
    wr(SWT_OFF_CTRL, 8'h08);
    rise(256 - 8);
    rd(SWT_OFF_COUNT, r);
    rd(SWT_OFF_CTRL, 8'h18);
    `CHK("service", 1'b1, wake_service_req)
    `CHK("osc_keep", 1'b1, slow_osc_keep)
    `CHK("events", 32'd1, ev_count)
    rd(SWT_OFF_IRQ_STAT, 8'h03);
    wr(SWT_OFF_IRQ_MASK, 8'h01);
    @(negedge clk);
    `CHK("irq", 1'b1, irq)
    wr(SWT_OFF_IRQ_STAT, 8'h01);
    @(negedge clk);
    `CHK("irq", 1'b0, irq)
    rd(SWT_OFF_IRQ_STAT, 8'h02);
    k = $urandom_range(1, 5);
    rise(k);
    rd(SWT_OFF_CTRL, 8'h18);
    @(posedge clk);
    global_interrupt_enable <= 1'b0;
    @(negedge clk);
    `CHK("service", 1'b0, wake_service_req)
    @(posedge clk);
    global_interrupt_enable <= 1'b1;
    wr(SWT_OFF_CTRL, 8'h00);
    rise(3);
    rd(SWT_OFF_COUNT, r + 8'(k));
    rd(SWT_OFF_CTRL, 8'h00);
    `CHK("service", 1'b0, wake_service_req)
    `CHK("osc_keep", 1'b0, slow_osc_keep)
    `CHK("events", 32'd1, ev_count)
    wrap_up;
  end
endmodule
bind swt_timer swt_timer_properties u_props (.clk(clk), .rstn(rstn), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .wake_interrupt_enable(wake_interrupt_enable),
  .global_interrupt_enable(global_interrupt_enable), .wake_service_req(wake_service_req),
  .irq(irq), .wake_event(wake_event), .slow_osc_keep(slow_osc_keep));
`default_nettype wire
